// *** rtl/ddcfc_pkg.sv ***
package ddcfc_pkg;
	// widths
	localparam int DW = 21;
	localparam int CW = 16;
	localparam int IW = 68;
	localparam int MW = 15;
	localparam int XW = 22;
	// register word addresses
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_DEC    = 8'h01;
	localparam logic [7:0] A_SCALE  = 8'h02;
	localparam logic [7:0] A_BOOST  = 8'h03;
	localparam logic [7:0] A_TUNE_A = 8'h04;
	localparam logic [7:0] A_TUNE_B = 8'h05;
	localparam logic [7:0] A_PHS_A  = 8'h06;
	localparam logic [7:0] A_PHS_B  = 8'h07;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [1:0] A_F1_PG  = 2'h1;
	localparam logic [1:0] A_F2_PG  = 2'h2;
	// control bit positions and reset values
	localparam int B_CHAN_A_DITHER_ENABLE = 0;
	localparam int B_CHAN_B_DITHER_ENABLE = 1;
	localparam int B_COMP   = 2;
	localparam int B_DEC4   = 3;
	localparam int B_BST_B  = 4;
	localparam logic        DITH_RST  = 1'b1;
	localparam logic [10:0] DEC_RST   = 11'h007;
	localparam logic [10:0] DEC_MIN   = 11'h007;
	localparam logic [5:0]  SCALE_MAX = 6'h28;
	localparam logic [5:0]  CIC_SHIFT = 6'h2c;
	localparam logic [5:0]  FIR_SHIFT = 6'h0f;
	localparam logic [2:0]  EXP_MAX   = 3'h7;
	// dither generators
	localparam logic [15:0] LFSR_POLY = 16'hb400;
	localparam logic [15:0] SEED_A    = 16'h0001;
	localparam logic [15:0] SEED_B    = 16'hfffe;

	typedef struct packed {
		logic        chan_a_dither_enable;
		logic        chan_b_dither_enable;
		logic        comp_off;
		logic        dec4;
		logic [10:0] dec;
		logic [5:0]  scale;
		logic [2:0]  boost_a;
		logic [2:0]  boost_b;
		logic [31:0] tune_a;
		logic [31:0] tune_b;
		logic [15:0] phase_a;
		logic [15:0] phase_b;
	} ddcfc_cfg_s;

	typedef struct packed {
		logic        we;
		logic [5:0]  idx;
		logic [15:0] data;
	} ddcfc_cwr_s;

	// arithmetic shift by sh+1 with round half up, clip to DW bits
	function automatic logic [DW-1:0] ddcfc_rnd_sat(input logic signed [IW-1:0] v,
			input logic [5:0] sh);
		logic signed [IW-1:0] t;
		t = (v >>> sh) + IW'(1);
		t = t >>> 1;
		if (t[IW-1:DW-1] != {(IW-DW+1){t[IW-1]}})
			ddcfc_rnd_sat = {t[IW-1], {(DW-1){~t[IW-1]}}};
		else
			ddcfc_rnd_sat = t[DW-1:0];
	endfunction : ddcfc_rnd_sat
endpackage : ddcfc_pkg

// *** rtl/ddcfc_chain.sv ***
// Notes on behaviour
// - all sample words are two's complement
// - phase offset unsigned 16 bits, 2pi/65536 each
// - two dither generators, seeds far apart
// - dither on after reset, separate enables
// - four stage CIC decimates by 8..2048
// - decimation register holds N minus one
// - shift-up gain is 2^(scale-44), scale 0..40
// - boost shifts left 0..7, round to 21
// - boost overflow clips to full scale
// - each channel has own boost setting
// - first FIR 21 symmetric taps, decimate 2
// - first FIR gain is coefficient sum / 2^16
// - first FIR loads 11 coefficients, mirrored
// - second FIR 63 taps, decimate 2 or 4
// - second FIR loads 32 coefficients, mirrored
// - second FIR gain is coefficient sum / 2^16
// - mixer contributes a one half gain
// - amplifier step shift cancels amplifier gain
// - latency 149N or 275N sample clocks
// - all filters linear phase
// - both FIR outputs saturate, never wrap
// - tuning word 32 bit two's complement
// - sync flushes data, nco, dither, decimation count
`timescale 1ns/1ps
`default_nettype none

module ddcfc_fir #(
	parameter int TAPS = 21
) (
	// clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         reset_n,
	// control
	input  wire logic                         flush,
	input  wire logic                         dec4,
	input  wire ddcfc_pkg::ddcfc_cwr_s        cwr,
	// samples
	input  wire logic                         in_valid,
	input  wire logic [ddcfc_pkg::DW-1:0]     in_data,
	output logic                              out_valid,
	output logic [ddcfc_pkg::DW-1:0]          out_data
);
	localparam int HALF = (TAPS + 1) / 2;
	localparam int DW = ddcfc_pkg::DW;
	if (TAPS % 2 == 0 || HALF > 64) begin : g_bad_taps
		$error("ddcfc_fir: TAPS must be odd and at most 127");
	end
	typedef struct packed {
		logic [TAPS-1:0][DW-1:0]          line;
		logic [TAPS-1:0][DW-1:0]          snap;
		logic [HALF-1:0][ddcfc_pkg::CW-1:0] coef;
		logic [1:0]                       ph;
		logic                             busy;
		logic [5:0]                       k;
		logic signed [47:0]               acc;
		logic                             out_valid;
		logic [DW-1:0]                    out_data;
	} ddcfc_fir_s;
	ddcfc_fir_s q;
	ddcfc_fir_s n;

	always_comb begin
		logic fire;
		logic last;
		logic signed [DW:0] sum;
		logic signed [37:0] prod;
		logic signed [47:0] acc_n;
		fire = 1'b0;
		last = 1'b0;
		sum = '0;
		prod = '0;
		acc_n = '0;
		n = q;
		n.out_valid = 1'b0;
		// host may rewrite taps at any time; results meanwhile are not trusted
		if (cwr.we && cwr.idx < 6'(HALF)) begin
			n.coef[cwr.idx] = cwr.data;
		end
		if (flush) begin
			n.line = '0;
			n.snap = '0;
			n.ph = 2'h0;
			n.busy = 1'b0;
			n.acc = '0;
		end else begin
			if (q.busy) begin
				// same coefficient feeds both mirror taps
				last = (q.k == 6'(HALF - 1));
				sum = last ? {q.snap[q.k][DW-1], q.snap[q.k]}
					: {q.snap[q.k][DW-1], q.snap[q.k]}
					+ {q.snap[TAPS-1-q.k][DW-1], q.snap[TAPS-1-q.k]};
				prod = sum * $signed(q.coef[q.k]);
				acc_n = q.acc + 48'(prod);
				n.acc = acc_n;
				n.k = q.k + 6'h1;
				if (last) begin
					n.busy = 1'b0;
					n.out_valid = 1'b1;
					// scale by 2^-16 and clip
					n.out_data = ddcfc_pkg::ddcfc_rnd_sat(ddcfc_pkg::IW'(acc_n),
						ddcfc_pkg::FIR_SHIFT);
				end
			end
			if (in_valid) begin
				n.line = {q.line[TAPS-2:0], in_data};
				// decimate by two, or four when asked
				fire = dec4 ? (q.ph == 2'h3) : q.ph[0];
				n.ph = fire ? 2'h0 : q.ph + 2'h1;
				if (fire) begin
					// snapshot lets the next input arrive mid-sum
					n.snap = n.line;
					n.busy = 1'b1;
					n.k = 6'h0;
					n.acc = '0;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign out_valid = q.out_valid;
	assign out_data  = q.out_data;
endmodule : ddcfc_fir

module ddcfc_chain #(
	parameter int CHAN_B = 0
) (
	// clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     reset_n,
	// sync pin, active low
	input  wire logic                     sync_n,
	// mixer samples and amplifier step code
	input  wire logic [ddcfc_pkg::MW-1:0] mix_i,
	input  wire logic [ddcfc_pkg::MW-1:0] mix_q,
	input  wire logic [2:0]               amp_step,
	// register port
	input  wire logic [7:0]               reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic [31:0]                   reg_rdata,
	// nco phase to the mixers
	output logic [15:0]                   nco_phase_a,
	output logic [15:0]                   nco_phase_b,
	// decimated output
	output logic                          out_valid,
	output logic [ddcfc_pkg::DW-1:0]      out_i,
	output logic [ddcfc_pkg::DW-1:0]      out_q
);
	localparam int IW = ddcfc_pkg::IW;
	localparam int DW = ddcfc_pkg::DW;
	if (CHAN_B < 0 || CHAN_B > 1) begin : g_bad_chan
		$error("ddcfc_chain: CHAN_B must be 0 or 1");
	end
	typedef struct packed {
		logic                        sync_meta;
		logic                        sync_q;
		ddcfc_pkg::ddcfc_cfg_s       cfg;
		logic [15:0]                 lfsr_a;
		logic [15:0]                 lfsr_b;
		logic [31:0]                 acc_a;
		logic [31:0]                 acc_b;
		logic [15:0]                 ph_a;
		logic [15:0]                 ph_b;
		logic [1:0][3:0][IW-1:0]     integ;
		logic [1:0][3:0][IW-1:0]     combd;
		logic [10:0]                 dcnt;
		logic                        cic_v;
		logic [1:0][DW-1:0]          cic_o;
		logic [31:0]                 rdata;
		logic [15:0]                 cnt;
	} ddcfc_top_s;
	ddcfc_top_s q;
	ddcfc_top_s n;
	logic                flush;
	ddcfc_pkg::ddcfc_cwr_s cwr1;
	ddcfc_pkg::ddcfc_cwr_s cwr2;
	logic [1:0]          f1_v;
	logic [1:0][DW-1:0]  f1_d;
	logic [1:0]          f2_v;
	logic [1:0][DW-1:0]  f2_d;

	assign flush = ~q.sync_q;

	function automatic logic [15:0] lfsr_step(input logic [15:0] l);
		lfsr_step = l[0] ? ((l >> 1) ^ ddcfc_pkg::LFSR_POLY) : (l >> 1);
	endfunction : lfsr_step

	// phase word: accumulator plus dither, truncated, then offset
	function automatic logic [15:0] nco_phase(input logic [31:0] acc, input logic [15:0] d,
			input logic en, input logic [15:0] offs);
		logic [31:0] t;
		t = acc + {16'h0, en ? d : 16'h0};
		nco_phase = t[31:16] + offs;
	endfunction : nco_phase

	always_comb begin
		cwr1 = '0;
		cwr2 = '0;
		if (reg_wr && reg_addr[7:6] == ddcfc_pkg::A_F1_PG) begin
			cwr1 = '{we: 1'b1, idx: reg_addr[5:0], data: reg_wdata[15:0]};
		end
		if (reg_wr && reg_addr[7:6] == ddcfc_pkg::A_F2_PG) begin
			cwr2 = '{we: 1'b1, idx: reg_addr[5:0], data: reg_wdata[15:0]};
		end
	end

	always_comb begin
		logic [2:0] ex;
		logic [2:0] bst;
		logic [ddcfc_pkg::XW-1:0] x;
		logic [IW-1:0] xs;
		logic [IW-1:0] v;
		logic [IW-1:0] t;
		logic [ddcfc_pkg::MW-1:0] m;
		ex = '0;
		bst = '0;
		x = '0;
		xs = '0;
		v = '0;
		t = '0;
		m = '0;
		n = q;
		n.sync_meta = sync_n;
		n.sync_q = q.sync_meta;
		n.cic_v = 1'b0;
		n.rdata = 32'h0;

		// register writes leave filter data alone
		if (reg_wr) begin
			case (reg_addr)
				ddcfc_pkg::A_CTRL: begin
					n.cfg.chan_a_dither_enable = reg_wdata[ddcfc_pkg::B_CHAN_A_DITHER_ENABLE];
					n.cfg.chan_b_dither_enable = reg_wdata[ddcfc_pkg::B_CHAN_B_DITHER_ENABLE];
					n.cfg.comp_off = reg_wdata[ddcfc_pkg::B_COMP];
					n.cfg.dec4 = reg_wdata[ddcfc_pkg::B_DEC4];
				end
				ddcfc_pkg::A_DEC: begin
					// below the minimum is lifted, the second FIR needs 32 cycles a sum, so 8 cycles a CIC sample
					n.cfg.dec = (reg_wdata[10:0] < ddcfc_pkg::DEC_MIN)
						? ddcfc_pkg::DEC_MIN : reg_wdata[10:0];
				end
				ddcfc_pkg::A_SCALE: begin
					n.cfg.scale = (reg_wdata[5:0] > ddcfc_pkg::SCALE_MAX)
						? ddcfc_pkg::SCALE_MAX : reg_wdata[5:0];
				end
				ddcfc_pkg::A_BOOST: begin
					n.cfg.boost_a = reg_wdata[2:0];
					n.cfg.boost_b = reg_wdata[ddcfc_pkg::B_BST_B+:3];
				end
				ddcfc_pkg::A_TUNE_A: n.cfg.tune_a = reg_wdata;
				ddcfc_pkg::A_TUNE_B: n.cfg.tune_b = reg_wdata;
				ddcfc_pkg::A_PHS_A:  n.cfg.phase_a = reg_wdata[15:0];
				ddcfc_pkg::A_PHS_B:  n.cfg.phase_b = reg_wdata[15:0];
				default: ;
			endcase
		end

		if (reg_rd) begin
			case (reg_addr)
				ddcfc_pkg::A_CTRL: n.rdata = {28'h0, q.cfg.dec4, q.cfg.comp_off,
					q.cfg.chan_b_dither_enable, q.cfg.chan_a_dither_enable};
				ddcfc_pkg::A_DEC:    n.rdata = {21'h0, q.cfg.dec};
				ddcfc_pkg::A_SCALE:  n.rdata = {26'h0, q.cfg.scale};
				ddcfc_pkg::A_BOOST:  n.rdata = {25'h0, q.cfg.boost_b, 1'b0, q.cfg.boost_a};
				ddcfc_pkg::A_TUNE_A: n.rdata = q.cfg.tune_a;
				ddcfc_pkg::A_TUNE_B: n.rdata = q.cfg.tune_b;
				ddcfc_pkg::A_PHS_A:  n.rdata = {16'h0, q.cfg.phase_a};
				ddcfc_pkg::A_PHS_B:  n.rdata = {16'h0, q.cfg.phase_b};
				ddcfc_pkg::A_STATUS: n.rdata = {q.cnt, 15'h0, flush};
				default: n.rdata = 32'h0;
			endcase
		end

		// nco phase, tuning word wraps as two's complement
		n.acc_a = q.acc_a + q.cfg.tune_a;
		n.acc_b = q.acc_b + q.cfg.tune_b;
		n.lfsr_a = lfsr_step(q.lfsr_a);
		n.lfsr_b = lfsr_step(q.lfsr_b);
		n.ph_a = nco_phase(q.acc_a, q.lfsr_a, q.cfg.chan_a_dither_enable, q.cfg.phase_a);
		n.ph_b = nco_phase(q.acc_b, q.lfsr_b, q.cfg.chan_b_dither_enable, q.cfg.phase_b);

		// amplifier step compensation; forced to max when turned off
		ex = q.cfg.comp_off ? ddcfc_pkg::EXP_MAX : amp_step;
		bst = (CHAN_B != 0) ? q.cfg.boost_b : q.cfg.boost_a;

		for (int r = 0; r < 2; r++) begin
			m = (r == 0) ? mix_i : mix_q;
			x = {{(ddcfc_pkg::XW-ddcfc_pkg::MW){m[ddcfc_pkg::MW-1]}}, m} << ex;
			// shift-up by scale; the fixed 2^-44 is folded into the output shift
			xs = IW'($signed(x)) << q.cfg.scale;
			// wraparound in the sums cancels in the combs
			n.integ[r][0] = q.integ[r][0] + xs;
			for (int j = 1; j < 4; j++) begin
				n.integ[r][j] = q.integ[r][j] + q.integ[r][j-1];
			end
			if (q.dcnt == 11'h0) begin
				v = q.integ[r][3];
				for (int j = 0; j < 4; j++) begin
					t = v - q.combd[r][j];
					n.combd[r][j] = v;
					v = t;
				end
				// 2^-44 shift-up, 1/2 mixer loss, boost, round, clip
				n.cic_o[r] = ddcfc_pkg::ddcfc_rnd_sat(v, ddcfc_pkg::CIC_SHIFT - {3'h0, bst});
			end
		end

		if (q.dcnt == 11'h0) begin
			n.dcnt = q.cfg.dec;
			n.cic_v = 1'b1;
		end else begin
			n.dcnt = q.dcnt - 11'h1;
		end

		if (f2_v[0]) begin
			n.cnt = q.cnt + 16'h1;
		end

		// sync holds the data path and nco in their start state
		if (flush) begin
			n.integ = '0;
			n.combd = '0;
			n.cic_o = '0;
			n.cic_v = 1'b0;
			n.dcnt = 11'h0;
			n.acc_a = 32'h0;
			n.acc_b = 32'h0;
			n.lfsr_a = ddcfc_pkg::SEED_A;
			n.lfsr_b = ddcfc_pkg::SEED_B;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.cfg.chan_a_dither_enable <= ddcfc_pkg::DITH_RST;
			q.cfg.chan_b_dither_enable <= ddcfc_pkg::DITH_RST;
			q.cfg.dec <= ddcfc_pkg::DEC_RST;
			q.lfsr_a <= ddcfc_pkg::SEED_A;
			q.lfsr_b <= ddcfc_pkg::SEED_B;
		end else begin
			q <= n;
		end
	end

	// latency follows from the tap counts of the three stages
	for (genvar r = 0; r < 2; r++) begin : g_rail
		ddcfc_fir #(
			.TAPS (21)
		) u_first_fir (
			.sys_clk   (sys_clk),
			.reset_n   (reset_n),
			.flush     (flush),
			.dec4      (1'b0),
			.cwr       (cwr1),
			.in_valid  (q.cic_v),
			.in_data   (q.cic_o[r]),
			.out_valid (f1_v[r]),
			.out_data  (f1_d[r])
		);
		ddcfc_fir #(
			.TAPS (63)
		) u_second_fir (
			.sys_clk   (sys_clk),
			.reset_n   (reset_n),
			.flush     (flush),
			.dec4      (q.cfg.dec4),
			.cwr       (cwr2),
			.in_valid  (f1_v[r]),
			.in_data   (f1_d[r]),
			.out_valid (f2_v[r]),
			.out_data  (f2_d[r])
		);
	end

	assign reg_rdata   = q.rdata;
	assign nco_phase_a = q.ph_a;
	assign nco_phase_b = q.ph_b;
	assign out_valid   = f2_v[0];
	assign out_i       = f2_d[0];
	assign out_q       = f2_d[1];
endmodule : ddcfc_chain

`default_nettype wire

// *** tb/ddcfc_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddcfc_props (
	// clock and reset
	input wire logic                     sys_clk,
	input wire logic                     reset_n,
	// controls
	input wire logic                     sync_n,
	input wire logic [7:0]               reg_addr,
	input wire logic [31:0]              reg_wdata,
	input wire logic                     reg_wr,
	input wire logic                     reg_rd,
	// results
	input wire logic [31:0]              reg_rdata,
	input wire logic                     out_valid,
	input wire logic [ddcfc_pkg::DW-1:0] out_i,
	input wire logic [ddcfc_pkg::DW-1:0] out_q
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its slot");
	dec_range_a: assert property (reg_rd && reg_addr == ddcfc_pkg::A_DEC |=>
		reg_rdata >= 32'h7 && reg_rdata <= 32'h7ff) else $error("decimation out of range");
	scale_cap_a: assert property (reg_rd && reg_addr == ddcfc_pkg::A_SCALE |=>
		reg_rdata <= 32'h28) else $error("scale above limit");
	coef_wo_a: assert property (reg_rd && reg_addr[7:6] != 2'h0 |=>
		reg_rdata == 32'h0) else $error("coefficient readable");
	boost_echo_a: assert property (reg_wr && reg_addr == ddcfc_pkg::A_BOOST ##1
		reg_rd && reg_addr == ddcfc_pkg::A_BOOST |=>
		(reg_rdata & 32'h77) == ($past(reg_wdata, 2) & 32'h77)) else $error("boost lost");
	sync_quiet_a: assert property (!sync_n [*4] |-> !out_valid)
		else $error("output during sync");
	out_spacing_a: assert property (out_valid |=> !out_valid [*8])
		else $error("outputs too close");
	// sync lags two cycles through the synchroniser, so wait it out
	out_hold_a: assert property (sync_n [*6] ##0 !out_valid |->
		$stable(out_i) && $stable(out_q)) else $error("output moved without valid");
endmodule : ddcfc_props

bind ddcfc_chain ddcfc_props u_props (.sys_clk(sys_clk), .reset_n(reset_n), .sync_n(sync_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .out_valid(out_valid), .out_i(out_i), .out_q(out_q));
`default_nettype wire

// *** tb/ddcfc_mixer_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddcfc_mixer_src (
	// clock
	input  wire logic        sys_clk,
	// requested levels
	input  wire logic [14:0] lvl_i,
	input  wire logic [14:0] lvl_q,
	input  wire logic [2:0]  step,
	// toward the chain
	output logic      [14:0] mix_i,
	output logic      [14:0] mix_q,
	output logic      [2:0]  amp_step
);
	initial begin
		mix_i = 15'h0;
		mix_q = 15'h0;
		amp_step = 3'h0;
	end
	// one register stage, like the real mixer output
	always @(posedge sys_clk) begin
		mix_i <= lvl_i;
		mix_q <= lvl_q;
		amp_step <= step;
	end
endmodule : ddcfc_mixer_src
`default_nettype wire

// *** tb/test_ddc_channel_filter_chain.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_ddc_channel_filter_chain;
	typedef struct {
		logic [14:0] mi, mq;
		logic [2:0]  st, bo;
		logic        co;
		logic [20:0] ei, eq;
	} ddcfc_row_s;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        sync_n = 1'b1;
	logic [14:0] lvl_i = 15'h0, lvl_q = 15'h0, mix_i, mix_q;
	logic [2:0]  step = 3'h0, amp_step;
	logic [7:0]  reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, out_valid, q;
	logic [15:0] nco_phase_a, nco_phase_b, pa, pb;
	logic [20:0] out_i, out_q;
	int          n_mismatch = 0, tests_run = 0, k;
	// unity filters, scale 32 and N=8: out = mix * 2^exp * 2^boost / 2
	ddcfc_row_s rows[6] = '{
		'{15'h3e8, 15'h7c18, 3'h0, 3'h0, 1'b0, 21'h1f4, 21'h1ffe0c},
		'{15'h3e9, 15'h7c17, 3'h0, 3'h0, 1'b0, 21'h1f5, 21'h1ffe0c},
		'{15'h3e8, 15'h7c18, 3'h3, 3'h0, 1'b0, 21'hfa0, 21'h1ff060},
		'{15'h3e8, 15'h7c18, 3'h0, 3'h4, 1'b0, 21'h1f40, 21'h1fe0c0},
		'{15'h3e8, 15'h7c18, 3'h3, 3'h0, 1'b1, 21'hfa00, 21'h1f0600},
		'{15'h3fff, 15'h4000, 3'h7, 3'h7, 1'b0, 21'hfffff, 21'h100000}};

	always #4 sys_clk = ~sys_clk;

	ddcfc_mixer_src mix (.sys_clk(sys_clk), .lvl_i(lvl_i), .lvl_q(lvl_q), .step(step),
		.mix_i(mix_i), .mix_q(mix_q), .amp_step(amp_step));
	ddcfc_chain #(.CHAN_B(0)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .sync_n(sync_n),
		.mix_i(mix_i), .mix_q(mix_q), .amp_step(amp_step), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.nco_phase_a(nco_phase_a), .nco_phase_b(nco_phase_b), .out_valid(out_valid),
		.out_i(out_i), .out_q(out_q));

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
	endtask : bus

	task automatic idle;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask : idle

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		idle;
		#1;
		chk($sformatf("reg %h", a), reg_rdata & m, e);
	endtask : rd

	// k ends as the cycle count since the call
	task automatic wv;
		k = 0;
		do begin
			@(posedge sys_clk);
			#1;
			k++;
		end while (out_valid !== 1'b1 && k < 9000);
		if (k >= 9000)
			chk("out_valid", 32'h0, 32'h1);
	endtask : wv

	task automatic gap(input logic [31:0] d, input logic [31:0] c, input logic [31:0] e);
		wr(ddcfc_pkg::A_DEC, d);
		wr(ddcfc_pkg::A_CTRL, c);
		idle;
		// outputs straddling the change are uneven, only the last gap is clean
		repeat (4) wv;
		chk("spacing", 32'(k), e);
	endtask : gap

	initial begin
		repeat (4) @(posedge sys_clk);
		#1;
		chk("reset out", 32'(out_i) | 32'(out_q) | 32'(out_valid), 32'h0);
		@(posedge sys_clk);
		reset_n <= 1'b1;
		rd(ddcfc_pkg::A_CTRL, '1, 32'h3);
		rd(ddcfc_pkg::A_DEC, '1, 32'h7);
		wr(ddcfc_pkg::A_DEC, 32'h3);
		rd(ddcfc_pkg::A_DEC, '1, 32'h7);
		wr(ddcfc_pkg::A_SCALE, 32'h3f);
		rd(ddcfc_pkg::A_SCALE, '1, 32'h28);
		rd(8'h09, '1, 32'h0);
		wr(8'h4b, 32'h7fff);
		wr(8'ha0, 32'h7fff);
		rd(8'h48, '1, 32'h0);
		// taps 8,9 and 29,30 mirrored give a sum of exactly 2^16
		wr(8'h48, 32'h4000);
		wr(8'h49, 32'h4000);
		wr(8'h9d, 32'h4000);
		wr(8'h9e, 32'h4000);
		wr(ddcfc_pkg::A_SCALE, 32'h20);
		foreach (rows[r]) begin
			idle;
			lvl_i <= rows[r].mi;
			lvl_q <= rows[r].mq;
			step <= rows[r].st;
			wr(ddcfc_pkg::A_CTRL, {28'h0, 1'b0, rows[r].co, 2'h3});
			wr(ddcfc_pkg::A_BOOST, {25'h0, ~rows[r].bo, 1'b0, rows[r].bo});
			rd(ddcfc_pkg::A_BOOST, '1, {25'h0, ~rows[r].bo, 1'b0, rows[r].bo});
			repeat (80) wv;
			chk("out_i", 32'(out_i), 32'(rows[r].ei));
			chk("out_q", 32'(out_q), 32'(rows[r].eq));
		end
		gap(32'h7, 32'h3, 32'd32);
		gap(32'h9, 32'h3, 32'd40);
		gap(32'h7, 32'hb, 32'd64);
		gap(32'h7ff, 32'h3, 32'd8192);
		wr(ddcfc_pkg::A_DEC, 32'h7);
		idle;
		sync_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		q = 1'b0;
		repeat (40) begin
			@(posedge sys_clk);
			#1;
			q = q | out_valid;
		end
		chk("quiet", 32'(q), 32'h0);
		rd(ddcfc_pkg::A_STATUS, 32'h1, 32'h1);
		@(posedge sys_clk);
		sync_n <= 1'b1;
		rd(ddcfc_pkg::A_SCALE, '1, 32'h20);
		wv;
		wr(ddcfc_pkg::A_CTRL, 32'h0);
		wr(ddcfc_pkg::A_PHS_A, 32'hc001);
		wr(ddcfc_pkg::A_TUNE_A, 32'h00010000);
		wr(ddcfc_pkg::A_TUNE_B, 32'hffff0000);
		idle;
		repeat (3) @(posedge sys_clk);
		#1;
		pa = nco_phase_a;
		pb = nco_phase_b;
		@(posedge sys_clk);
		#1;
		chk("step a", 32'(16'(nco_phase_a - pa)), 32'h1);
		chk("step b", 32'(16'(nco_phase_b - pb)), 32'hffff);
		wr(ddcfc_pkg::A_TUNE_A, 32'h0);
		idle;
		sync_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		sync_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		#1;
		chk("phase a", 32'(nco_phase_a), 32'hc001);
		end_sim;
	end

	initial begin
		repeat (90000) @(posedge sys_clk);
		n_mismatch++;
		end_sim;
	end
endmodule : test_ddc_channel_filter_chain
`default_nettype wire
